//--- rtc_alarm_pkg.sv
// Constants and types shared by the alarm and clock-control block
package rtc_alarm_pkg;

	// ------------------------------------------------------------
	// Serial commands and frame lengths
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_WR_ALARM = 8'h10;
	localparam logic [7:0] CMD_WR_CTRL  = 8'h11;
	localparam logic [7:0] CMD_RD_CTRL  = 8'h51;
	localparam logic [7:0] CMD_WR_WDOG  = 8'h12;
	localparam logic [7:0] CMD_RD_FLAG  = 8'h53;
	localparam int         CMD_BITS     = 8;
	localparam int         CTRL_BITS    = 16;
	localparam int         ALARM_BITS   = 24;
	localparam int         ALARM_WIDTH  = 20;
	localparam logic [5:0] UNLOCK_EDGE  = 6'd16;

	// ------------------------------------------------------------
	// Control register layout and reset value
	// ------------------------------------------------------------
	localparam int         B_AWE   = 15;
	localparam int         B_ARM   = 14;
	localparam int         B_RWE   = 12;
	localparam int         B_RUN   = 11;
	localparam int         B_OSC   = 10;
	localparam int         B_FLL   = 9;
	localparam int         B_HFC   = 8;
	localparam int         B_SEL   = 5;
	localparam int         B_DIR   = 4;
	localparam int         B_CK32  = 3;
	localparam int         B_FAST_CLOCK_OUT_BUFFER_ON  = 2;
	localparam int         B_POL   = 1;
	localparam int         B_WDE   = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0f2e;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 200_000_000;
	localparam int SUB_HZ       = 256;
	localparam int SUB_CYCLES   = CLK_HZ / SUB_HZ;
	localparam int WDOG_MS      = 500;
	localparam int WDOG_CYCLES  = (CLK_HZ / 1000) * WDOG_MS;
	localparam int FAST_HZ_X10  = 49_152_000;

	typedef enum logic [1:0] {
		SP_IDLE,
		SP_CMD,
		SP_DATA
	} spi_state_t;

endpackage

//--- rtc_counter.sv
// Seconds and subsecond counters with the alarm comparator
`timescale 1ns/1ps
module rtc_counter
	import rtc_alarm_pkg::*;
#(
	parameter int SUB_DIV = SUB_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_run,
	input  wire logic                   i_arm,
	input  wire logic [ALARM_WIDTH-1:0] i_alarm,
	output logic      [31:0]            o_seconds,
	output logic      [7:0]             o_sub,
	output logic                        o_match
);
	logic [31:0] div_reg;
	logic        tick;

	assign tick = i_run && (div_reg == 32'(SUB_DIV - 1));

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 32'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sub     <= '0;
			o_seconds <= '0;
		end else if (tick) begin
			o_sub <= o_sub + 8'h1;
			if (o_sub == 8'hff) begin
				o_seconds <= o_seconds + 32'h1;
			end
		end
	end

	// One compare per second increment, on the new count
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_match <= 1'b0;
		end else begin
			o_match <= tick && (o_sub == 8'hff) && i_arm &&
				((o_seconds[ALARM_WIDTH-1:0] + 20'h1) == i_alarm);
		end
	end
endmodule

//--- alarm_clock_ctrl.sv
// Serial port, control register, alarm and clock outputs
//
// What this block does
// - Alarm compares only the low 20 seconds bits with stored value.
// - Select rising before last alarm bit discards partial write.
// - Alarm match sets flag and drives interrupt unless masked.
// - Alarm while asleep returns the device to normal mode.
// - Alarm clears its arm bit itself; each alarm fires once.
// - Mask never suppresses alarm routed to a user I/O pin.
// - Alarm value and arm bit write only when previously unlocked.
// - Counter unlock takes effect after 16th edge; gates run bit.
// - Run bit starts 32-bit seconds and 8-bit subsecond; resets one.
// - Crystal oscillator enable powers slow oscillator; resets one.
// - Fast clock runs unlocked without lock; lock toggle glitch free.
// - Fast clock pin toggles only with both enables, else low.
// - Three-bit select picks fast clock frequency; resets to 001.
// - Direction bit: 0 drives slow clock pin, 1 takes it in.
// - Slow clock buffer acts only with oscillator on and output mode.
// - Polarity bit: 1 active-high interrupt, 0 active-low; resets one.
// - Watchdog on drives reset low within 500ms unless serviced.
// - Subsecond at 256Hz; wrap increments the seconds counter.
`timescale 1ns/1ps
module alarm_clock_ctrl
	import rtc_alarm_pkg::*;
#(
	parameter int SUB_DIV  = SUB_CYCLES,
	parameter int WDOG_DIV = WDOG_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_sclk,
	input  wire logic                   i_cs_n,
	input  wire logic                   i_mosi,
	input  wire logic                   i_alarm_mask,
	input  wire logic                   i_alarm_to_user_io,
	input  wire logic                   i_sleep_req,
	input  wire logic                   i_slow_clock_in,
	output logic                        o_miso,
	output logic                        o_irq,
	output logic                        o_user_io_alarm,
	output logic                        o_sleep,
	output logic                        o_reset_n,
	output logic                        o_fast_clock,
	output logic                        o_slow_clock_out,
	output logic                        o_slow_clock_oe,
	output logic                        o_slow_clock_sel_ext,
	output logic                        o_xtal_osc_on,
	output logic                        o_freq_lock_on,
	output logic                        o_fast_clock_osc_on,
	output logic                        o_alarm_flag,
	output logic [ALARM_WIDTH-1:0]      o_alarm_second_bits
);
	import rtc_alarm_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [1:0] slow_sync_reg;
	logic       sclk_d_reg;
	logic       slow_d_reg;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_n;
	logic       mosi;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sclk_sync_reg <= '0;
			cs_sync_reg   <= 2'b11;
			mosi_sync_reg <= '0;
			slow_sync_reg <= '0;
			sclk_d_reg    <= 1'b0;
			slow_d_reg    <= 1'b0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
			cs_sync_reg   <= {cs_sync_reg[0], i_cs_n};
			mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
			slow_sync_reg <= {slow_sync_reg[0], i_slow_clock_in};
			sclk_d_reg    <= sclk_sync_reg[1];
			slow_d_reg    <= slow_sync_reg[1];
		end
	end

	assign sclk_rise = sclk_sync_reg[1] && !sclk_d_reg;
	assign sclk_fall = !sclk_sync_reg[1] && sclk_d_reg;
	assign cs_n      = cs_sync_reg[1];
	assign mosi      = mosi_sync_reg[1];

	// ------------------------------------------------------------
	// Serial frame: 8-bit command then data, MSB first
	// ------------------------------------------------------------
	spi_state_t  sp_state_reg;
	logic [7:0]  cmd_reg;
	logic [23:0] shift_reg;
	logic [5:0]  bit_cnt_reg;
	logic [15:0] tx_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic        counter_unlock_reg;
	logic        wr_ctrl;
	logic        wr_alarm;
	logic        wr_wdog;
	logic        unlock_edge;
	logic [23:0] shift_next;

	assign shift_next  = {shift_reg[22:0], mosi};
	assign wr_ctrl     = sp_state_reg == SP_DATA && sclk_rise &&
		cmd_reg == CMD_WR_CTRL && bit_cnt_reg == 6'(CTRL_BITS - 1);
	assign wr_alarm    = sp_state_reg == SP_DATA && sclk_rise &&
		cmd_reg == CMD_WR_ALARM && bit_cnt_reg == 6'(ALARM_BITS - 1);
	assign wr_wdog     = sp_state_reg == SP_DATA && sclk_rise &&
		cmd_reg == CMD_WR_WDOG && bit_cnt_reg == 6'(CMD_BITS - 1);
	assign unlock_edge = wr_ctrl;

	always_ff @(posedge i_clk) begin
		if (i_rst || cs_n) begin
			sp_state_reg <= SP_IDLE;
			bit_cnt_reg  <= '0;
			cmd_reg      <= '0;
			shift_reg    <= '0;
		end else begin
			case (sp_state_reg)
				SP_IDLE: begin
					sp_state_reg <= SP_CMD;
					bit_cnt_reg  <= '0;
				end
				SP_CMD: begin
					if (sclk_rise) begin
						shift_reg <= shift_next;
						if (bit_cnt_reg == 6'(CMD_BITS - 1)) begin
							cmd_reg      <= shift_next[7:0];
							bit_cnt_reg  <= '0;
							sp_state_reg <= SP_DATA;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 6'h1;
						end
					end
				end
				SP_DATA: begin
					if (sclk_rise) begin
						shift_reg   <= shift_next;
						bit_cnt_reg <= bit_cnt_reg + 6'h1;
					end
				end
				default: sp_state_reg <= SP_IDLE;
			endcase
		end
	end

	// Read data shifts out on falling edges
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_reg <= '0;
			o_miso <= 1'b0;
		end else if (sp_state_reg == SP_CMD && sclk_rise &&
			bit_cnt_reg == 6'(CMD_BITS - 1)) begin
			if (shift_next[7:0] == CMD_RD_CTRL) begin
				tx_reg <= ctrl_reg;
			end else if (shift_next[7:0] == CMD_RD_FLAG) begin
				tx_reg <= {o_alarm_flag, 15'h0};
			end else begin
				tx_reg <= '0;
			end
		end else if (sp_state_reg == SP_DATA && sclk_fall) begin
			o_miso <= tx_reg[15];
			tx_reg <= {tx_reg[14:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic match;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = shift_next[15:0];
			ctrl_next[13] = 1'b0;
			if (!ctrl_reg[B_AWE]) begin
				ctrl_next[B_ARM] = ctrl_reg[B_ARM];
			end
			if (!counter_unlock_reg) begin
				ctrl_next[B_RUN] = ctrl_reg[B_RUN];
			end
			// Slow buffer only sticks when oscillator on and pin output
			if (!ctrl_next[B_OSC] || ctrl_next[B_DIR]) begin
				ctrl_next[B_CK32] = 1'b0;
			end
		end
		if (match) begin
			ctrl_next[B_ARM] = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Unlock written in a frame counts only from the next frame
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			counter_unlock_reg <= 1'b0;
		end else if (unlock_edge && bit_cnt_reg == 6'(UNLOCK_EDGE - 1)) begin
			counter_unlock_reg <= shift_next[B_RWE];
		end
	end

	// ------------------------------------------------------------
	// Alarm value, flag, interrupt and wake
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_alarm_second_bits <= '0;
		end else if (wr_alarm && ctrl_reg[B_AWE]) begin
			o_alarm_second_bits <= shift_next[ALARM_BITS-1:
				ALARM_BITS-ALARM_WIDTH];
		end
	end

	rtc_counter #(
		.SUB_DIV (SUB_DIV)
	) u_counter (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_run     (ctrl_reg[B_RUN]),
		.i_arm     (ctrl_reg[B_ARM]),
		.i_alarm   (o_alarm_second_bits),
		.o_seconds (),
		.o_sub     (),
		.o_match   (match)
	);

	// Flag set wins over a read-clear in the same cycle
	logic flag_rd;
	assign flag_rd = sp_state_reg == SP_CMD && sclk_rise &&
		bit_cnt_reg == 6'(CMD_BITS - 1) && shift_next[7:0] == CMD_RD_FLAG;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_alarm_flag <= 1'b0;
		end else if (match) begin
			o_alarm_flag <= 1'b1;
		end else if (flag_rd) begin
			o_alarm_flag <= 1'b0;
		end
	end

	logic irq_active;
	assign irq_active = (o_alarm_flag || match) && !i_alarm_mask;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq           <= !CTRL_RESET[B_POL];
			o_user_io_alarm <= 1'b0;
		end else begin
			o_irq           <= ctrl_reg[B_POL] ? irq_active : !irq_active;
			o_user_io_alarm <= i_alarm_to_user_io &&
				(o_alarm_flag || match);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sleep <= 1'b0;
		end else if (match) begin
			o_sleep <= 1'b0;
		end else if (i_sleep_req) begin
			o_sleep <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	logic [31:0] wdog_cnt_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst || !ctrl_reg[B_WDE] || wr_wdog) begin
			wdog_cnt_reg <= '0;
			o_reset_n    <= 1'b1;
		end else if (wdog_cnt_reg == 32'(WDOG_DIV - 1)) begin
			o_reset_n <= 1'b0;
		end else begin
			wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Clock outputs
	// ------------------------------------------------------------
	function automatic logic [11:0] fast_half_period(input logic [2:0] sel);
		case (sel)
			3'h0: fast_half_period = 12'(CLK_HZ / (FAST_HZ_X10 / 5));
			3'h1: fast_half_period = 12'(CLK_HZ / (FAST_HZ_X10 / 10));
			3'h2: fast_half_period = 12'(CLK_HZ / (FAST_HZ_X10 / 20));
			3'h3: fast_half_period = 12'(CLK_HZ / (FAST_HZ_X10 / 40));
			default: fast_half_period = 12'h0;
		endcase
	endfunction

	// 32.768kHz passes the slow clock; settings 5 to 7 divide it by 2, 4 and 8
	logic [2:0]  fast_sel;
	logic [11:0] fast_cnt_reg;
	logic [2:0]  slow_div_reg;
	logic        fast_run;
	logic        slow_rise;

	assign fast_sel  = ctrl_reg[B_SEL+2:B_SEL];
	assign fast_run  = ctrl_reg[B_HFC] && ctrl_reg[B_FAST_CLOCK_OUT_BUFFER_ON];
	assign slow_rise = slow_sync_reg[1] && !slow_d_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst || !fast_run) begin
			fast_cnt_reg <= '0;
			slow_div_reg <= '0;
			o_fast_clock <= 1'b0;
		end else if (!fast_sel[2]) begin
			if (fast_cnt_reg >= fast_half_period(fast_sel) - 12'h1) begin
				fast_cnt_reg <= '0;
				o_fast_clock <= !o_fast_clock;
			end else begin
				fast_cnt_reg <= fast_cnt_reg + 12'h1;
			end
		end else if (fast_sel[1:0] == 2'h0) begin
			o_fast_clock <= slow_sync_reg[1];
		end else if (slow_rise) begin
			slow_div_reg <= slow_div_reg + 3'h1;
			o_fast_clock <= slow_div_reg[fast_sel[1:0] - 2'h1];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_slow_clock_out     <= 1'b0;
			o_slow_clock_oe      <= 1'b0;
			o_slow_clock_sel_ext <= 1'b0;
			o_xtal_osc_on        <= 1'b1;
			o_freq_lock_on       <= 1'b1;
			o_fast_clock_osc_on  <= 1'b1;
		end else begin
			o_slow_clock_out     <= slow_sync_reg[1] && ctrl_reg[B_CK32];
			o_slow_clock_oe      <= !ctrl_reg[B_DIR] && ctrl_reg[B_CK32];
			o_slow_clock_sel_ext <= ctrl_reg[B_DIR];
			o_xtal_osc_on        <= ctrl_reg[B_OSC];
			o_freq_lock_on       <= ctrl_reg[B_FLL] && ctrl_reg[B_HFC];
			o_fast_clock_osc_on  <= ctrl_reg[B_HFC];
		end
	end
endmodule

//--- alarm_clock_ctrl_chk.sv
// Port checker for the alarm and clock-control block
`timescale 1ns/1ps
module alarm_clock_ctrl_chk
	import rtc_alarm_pkg::*;
#(
	parameter int SUB_DIV  = SUB_CYCLES,
	parameter int WDOG_DIV = WDOG_CYCLES
) (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire logic                   i_cs_n,
	input wire logic                   i_alarm_mask,
	input wire logic                   i_alarm_to_user_io,
	input wire logic                   o_irq,
	input wire logic                   o_user_io_alarm,
	input wire logic                   o_sleep,
	input wire logic                   o_reset_n,
	input wire logic                   o_fast_clock,
	input wire logic                   o_slow_clock_oe,
	input wire logic                   o_slow_clock_sel_ext,
	input wire logic                   o_xtal_osc_on,
	input wire logic                   o_freq_lock_on,
	input wire logic                   o_fast_clock_osc_on,
	input wire logic                   o_alarm_flag,
	input wire logic [ALARM_WIDTH-1:0] o_alarm_second_bits
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ----------
	// Alarm event
	// ----------
	sequence s_fire;
		$rose(o_alarm_flag);
	endsequence
	// Synced select lags the pin, so give it time to settle
	sequence s_cs_idle;
		i_cs_n [*8];
	endsequence

	a_irq_fire: assert property (
		s_fire ##0 !i_alarm_mask |-> ##[0:2] o_irq != $past(o_irq, 3))
		else $error("interrupt did not follow alarm");
	a_irq_masked: assert property (
		s_fire ##0 i_alarm_mask |-> $stable(o_irq) [*3])
		else $error("masked alarm moved interrupt");
	a_user_io: assert property (
		s_fire ##0 i_alarm_to_user_io |-> ##[0:2] o_user_io_alarm)
		else $error("user io missed alarm");
	a_wake_up: assert property (
		s_fire ##0 $past(o_sleep) |-> !o_sleep)
		else $error("alarm did not wake device");
	a_alarm_hold: assert property (
		s_cs_idle |-> $stable(o_alarm_second_bits))
		else $error("alarm value moved outside frame");
	a_flag_sticky: assert property (
		s_cs_idle ##0 o_alarm_flag |=> o_alarm_flag)
		else $error("alarm flag dropped without read");

	// ----------
	// Clocks and reset values
	// ----------
	a_reset_values: assert property ($fell(i_rst) |->
		o_reset_n && o_xtal_osc_on && o_freq_lock_on &&
		o_fast_clock_osc_on && !o_alarm_flag && !o_irq)
		else $error("wrong values after reset");
	a_fast_low: assert property (
		!o_fast_clock_osc_on [*3] |-> !o_fast_clock)
		else $error("fast clock moved while off");
	a_slow_oe: assert property (
		o_slow_clock_oe |-> o_xtal_osc_on && !o_slow_clock_sel_ext)
		else $error("slow clock driven while not allowed");
endmodule

bind alarm_clock_ctrl alarm_clock_ctrl_chk #(
	.SUB_DIV(SUB_DIV), .WDOG_DIV(WDOG_DIV)
) alarm_clock_ctrl_chk_inst (
	.i_clk, .i_rst, .i_cs_n, .i_alarm_mask, .i_alarm_to_user_io,
	.o_irq, .o_user_io_alarm, .o_sleep, .o_reset_n, .o_fast_clock,
	.o_slow_clock_oe, .o_slow_clock_sel_ext, .o_xtal_osc_on,
	.o_freq_lock_on, .o_fast_clock_osc_on, .o_alarm_flag,
	.o_alarm_second_bits
);

//--- spi_host_model.sv
// Serial host model that frames commands for the block
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic i_clk,
	input  wire logic i_miso,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_mosi
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	task automatic half(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Command then n data bits; select rises early after cut data bits
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] dat,
		input int n, input int cut, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, dat << (24 - n)};
		rd = '0;
		o_cs_n = 1'b0;
		for (int i = 0; i < 8 + n && i < 8 + cut; i++) begin
			o_mosi = sh[31 - i];
			half(12);
			o_sclk = 1'b1;
			rd = {rd[22:0], i_miso};
			half(13);
			o_sclk = 1'b0;
		end
		half(13);
		o_cs_n = 1'b1;
		// No pull on the data line, so released means changed
		o_mosi = ~o_mosi;
		half(25);
	endtask
endmodule

//--- testbench.sv
// Self-checking bench for the alarm and clock-control block
`timescale 1ns/1ps
module testbench;
	import rtc_alarm_pkg::*;
	localparam int SUB   = 4;
	localparam int WDOG  = 2000;
	localparam int SEC   = SUB * 256;
	localparam int LIMIT = 90000;
	localparam int SLOW_HZ = 32768;
	logic i_clk, i_rst, i_sclk, i_cs_n, i_mosi, i_alarm_mask;
	logic i_alarm_to_user_io, i_sleep_req, i_slow_clock_in;
	logic o_miso, o_irq, o_user_io_alarm, o_sleep, o_reset_n;
	logic o_fast_clock, o_slow_clock_out, o_slow_clock_oe;
	logic o_slow_clock_sel_ext, o_xtal_osc_on, o_freq_lock_on;
	logic o_fast_clock_osc_on, o_alarm_flag;
	logic [ALARM_WIDTH-1:0] o_alarm_second_bits;
	logic [23:0]            rd;
	int                     fails, num_checks, cyc, cyc0;

	alarm_clock_ctrl #(.SUB_DIV(SUB), .WDOG_DIV(WDOG)) alarm_clock_ctrl_inst (
		.i_clk, .i_rst, .i_sclk, .i_cs_n, .i_mosi, .i_alarm_mask,
		.i_alarm_to_user_io, .i_sleep_req, .i_slow_clock_in, .o_miso,
		.o_irq, .o_user_io_alarm, .o_sleep, .o_reset_n, .o_fast_clock,
		.o_slow_clock_out, .o_slow_clock_oe, .o_slow_clock_sel_ext,
		.o_xtal_osc_on, .o_freq_lock_on, .o_fast_clock_osc_on,
		.o_alarm_flag, .o_alarm_second_bits
	);
	spi_host_model spi_host_model_inst (.i_clk, .i_miso(o_miso),
		.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));

	always #2.5 i_clk = ~i_clk;
	always #15259 i_slow_clock_in = ~i_slow_clock_in;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			end_of_test();
		end
	end

	// ----------
	// Access tasks
	// ----------
	task automatic xf(input logic [7:0] c, input logic [23:0] d,
		input int n, input int cut);
		spi_host_model_inst.xfer(c, d, n, cut, rd);
	endtask
	task automatic wr(input logic [15:0] v);
		xf(CMD_WR_CTRL, {8'h00, v}, CTRL_BITS, 99);
	endtask
	task automatic rd16(input logic [7:0] c, output logic [15:0] v);
		xf(c, 24'h000000, CTRL_BITS, 99);
		v = rd[15:0];
	endtask
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rises(input int n, output int c);
		logic p;
		c = 0;
		p = o_fast_clock;
		repeat (n) begin
			@(negedge i_clk);
			if (o_fast_clock === 1'b1 && p === 1'b0) c++;
			p = o_fast_clock;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ----------
	// Tests
	// ----------
	initial begin
		int c, e, f, p;
		logic [15:0] v;
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_alarm_mask = 1'b0;
		i_alarm_to_user_io = 1'b1;
		i_sleep_req = 1'b0;
		i_slow_clock_in = 1'b0;
		fails = 0;
		num_checks = 0;
		cyc = 0;
		repeat (10) @(negedge i_clk);
		i_rst = 1'b0;
		cyc0 = cyc;
		repeat (4) @(negedge i_clk);
		rd16(CMD_RD_CTRL, v);
		chk("ctrl", 24'(CTRL_RESET), 24'(v));
		chk("slow oe", 24'h1, 24'(o_slow_clock_oe));
		$display("test reset done");
		xf(CMD_WR_ALARM, 24'h123450, ALARM_BITS, 99);
		chk("locked", 24'h0, 24'(o_alarm_second_bits));
		wr(16'h8f2e);
		// Pass 0 unmasked, pass 1 masked
		for (int m = 0; m < 2; m++) begin
			i_alarm_mask = m[0];
			i_sleep_req = 1'b1;
			e = (cyc - cyc0) / SEC + 5;
			xf(CMD_WR_ALARM, {20'(e), 4'h0}, ALARM_BITS, 99);
			chk("alarm", 24'(e), 24'(o_alarm_second_bits));
			xf(CMD_WR_ALARM, 24'hfffff0, ALARM_BITS, 12);
			chk("abort", 24'(e), 24'(o_alarm_second_bits));
			wr(16'hcf2e);
			rd16(CMD_RD_CTRL, v);
			chk("armed", 24'h1, 24'(v[B_ARM]));
			chk("asleep", 24'h1, 24'(o_sleep));
			i_sleep_req = 1'b0;
			for (c = 0; c < 8000 && o_alarm_flag !== 1'b1; c++)
				@(negedge i_clk);
			repeat (3) @(negedge i_clk);
			chk("irq", 24'(!m[0]), 24'(o_irq));
			chk("user io", 24'h1, 24'(o_user_io_alarm));
			chk("awake", 24'h0, 24'(o_sleep));
			rd16(CMD_RD_CTRL, v);
			chk("disarmed", 24'h0, 24'(v[B_ARM]));
			rd16(CMD_RD_FLAG, v);
			chk("flag read", 24'h1, 24'(v[15]));
			chk("flag clr", 24'h0, 24'(o_alarm_flag));
		end
		$display("test alarm done");
		wr(16'h872e);
		rd16(CMD_RD_CTRL, v);
		chk("run locked", 24'h1, 24'(v[B_RUN]));
		wr(16'h9f2e);
		wr(16'h972e);
		rd16(CMD_RD_CTRL, v);
		chk("run off", 24'h0, 24'(v[B_RUN]));
		$display("test run done");
		for (int s = 0; s < 5; s++) begin
			wr(16'h0f0e | 16'(s << B_SEL));
			f = s < 4 ? (FAST_HZ_X10 / 10) >> s : SLOW_HZ;
			p = s < 4 ? 2000 : 25000;
			e = int'((longint'(p) * f + CLK_HZ / 2) / CLK_HZ);
			rises(p, c);
			chk("fast", 24'h1, 24'(c >= e - 1 && c <= e + 1));
		end
		for (int k = 0; k < 2; k++) begin
			wr(k ? 16'h0e2e : 16'h0f2a);
			rises(500, c);
			chk("fast off", 24'h0, 24'(c));
		end
		wr(16'h093c);
		rises(500, c);
		rd16(CMD_RD_CTRL, v);
		chk("buffer bit", 24'h0, 24'(v[B_CK32]));
		chk("osc", 24'h0, 24'(o_xtal_osc_on));
		chk("lock", 24'h0, 24'(o_freq_lock_on));
		chk("unlocked fast", 24'h1, 24'(c > 0));
		chk("ext sel", 24'h1, 24'(o_slow_clock_sel_ext));
		chk("slow oe off", 24'h0, 24'(o_slow_clock_oe));
		chk("irq idle", 24'h1, 24'(o_irq));
		$display("test clocks done");
		wr(16'h0f2f);
		repeat (3) xf(CMD_WR_WDOG, 24'h000000, CMD_BITS, 99);
		chk("wdog kicked", 24'h1, 24'(o_reset_n));
		repeat (WDOG + 100) @(negedge i_clk);
		chk("wdog fired", 24'h0, 24'(o_reset_n));
		$display("test watchdog done");
		end_of_test();
	end
endmodule
